// >>> dv/tmic_ctrl_sva.sv
// Purpose: Port assertions for the modulation and illumination control
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every tmic_ctrl instance
`timescale 1ns/1ps
module tmic_ctrl_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       we_i,
  input wire logic       ack_o,
  input wire logic       intg_req_i,
  input wire logic       quad_start_i,
  input wire logic       subframe_start_i,
  input wire logic       illum_mod_pos_o,
  input wire logic       illum_mod_neg_o,
  input wire logic       light_driver_enable_o,
  input wire logic       shutter_switch_on_o,
  input wire logic       integrating_o,
  input wire logic [1:0] quad_index_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_pos_idle: assert property (!light_driver_enable_o |-> !illum_mod_pos_o)
    else $error("positive output high outside integration");
  chk_neg_idle: assert property (!light_driver_enable_o |-> illum_mod_neg_o)
    else $error("negative output low outside integration");
  chk_enable_lead: assert property ($rose(integrating_o) |-> $past(light_driver_enable_o))
    else $error("driver enable not ahead of integration");
  chk_enable_tail: assert property ($fell(integrating_o) |->
    light_driver_enable_o ##1 !light_driver_enable_o)
    else $error("driver enable not dropped after integration");
  chk_start_lead: assert property ($rose(intg_req_i) && !light_driver_enable_o
    |=> light_driver_enable_o)
    else $error("driver enable late on request");
  chk_shutter_intg: assert property (integrating_o |-> shutter_switch_on_o)
    else $error("shutter switch off while integrating");
  chk_quad_step: assert property (quad_start_i && !subframe_start_i
    && !(cyc_i && stb_i && we_i) |=> quad_index_o == $past(quad_index_o) + 2'h1)
    else $error("quad index did not step by one");
  chk_ack_once: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  chk_ack_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged next cycle");
  chk_pair_comp: assert property (illum_mod_neg_o == !illum_mod_pos_o)
    else $error("modulation outputs not complementary");
endmodule : tmic_ctrl_chk

bind tmic_ctrl tmic_ctrl_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o,
  .intg_req_i, .quad_start_i, .subframe_start_i, .illum_mod_pos_o, .illum_mod_neg_o,
  .light_driver_enable_o, .shutter_switch_on_o, .integrating_o, .quad_index_o);

// >>> dv/tmic_light_model.sv
// Purpose: External light driver seen from the modulation pins
// Assumes: Driver emits only while enabled
// Notes:   Counts light pulses, latches a fault on emission in standby
`timescale 1ns/1ps
module tmic_light_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic pos_i,
  input  wire logic neg_i,
  output int        pulses_o,
  output logic      fault_o
);
  logic pos_d;

  always @(posedge clk_i)
  begin
    pos_d <= pos_i;
    if (rst_i)
    begin
      pulses_o <= 0;
      fault_o  <= 1'b0;
    end
    else
    begin
      if (enable_i && pos_i && !pos_d)
        pulses_o <= pulses_o + 1;
      if (!enable_i && (pos_i || !neg_i))
        fault_o <= 1'b1;
    end
  end
endmodule : tmic_light_model

// >>> dv/tof_modulation_illum_control_bench.sv
// Purpose: Self-checking bench for the modulation and illumination control
// Assumes: Wishbone classic master, 20 MHz clock
// Notes:   Read results checked from a queue by a monitor
`timescale 1ns/1ps
module tof_modulation_illum_control_bench;
  logic        clk_i            = 1'b0;
  logic        rst_i            = 1'b1;
  logic        cyc_i            = 1'b0;
  logic        stb_i            = 1'b0;
  logic        we_i             = 1'b0;
  logic [7:0]  adr_i            = 8'h00;
  logic [3:0]  sel_i            = 4'hf;
  logic [31:0] dat_i            = 32'h0;
  logic        intg_req_i       = 1'b0;
  logic        quad_start_i     = 1'b0;
  logic        subframe_start_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o, illum_mod_pos_o, illum_mod_neg_o, pixel_demod_o;
  logic        light_driver_enable_o, shutter_switch_on_o, integrating_o;
  logic [1:0]  quad_index_o;
  logic [1:0]  off;
  logic        fault;
  int          pulses;
  int          fail_count  = 0;
  int          checks_done = 0;
  int          seed        = 32'h58488510;
  logic [31:0] exp_q[$];

  tmic_ctrl dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .intg_req_i, .quad_start_i, .subframe_start_i, .illum_mod_pos_o,
    .illum_mod_neg_o, .pixel_demod_o, .light_driver_enable_o, .shutter_switch_on_o,
    .integrating_o, .quad_index_o);
  tmic_light_model u_light (.clk_i, .rst_i, .enable_i(light_driver_enable_o),
    .pos_i(illum_mod_pos_o), .neg_i(illum_mod_neg_o), .pulses_o(pulses), .fault_o(fault));

  initial
    forever #25 clk_i = ~clk_i;

  // ------
  // Tasks
  // ------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    if (!w)
      exp_q.push_back(d);
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (!ack_o && i < 20);
    if (!ack_o)
    begin
      fail_count++;
      stop_test();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic pulse(input logic sf);
    @(posedge clk_i);
    subframe_start_i <= sf;
    quad_start_i     <= !sf;
    @(posedge clk_i);
    subframe_start_i <= 1'b0;
    quad_start_i     <= 1'b0;
    @(negedge clk_i);
  endtask : pulse

  task automatic run_intg(input int lead, input logic hold, input logic lvl);
    int c;
    int n;
    c = 0;
    @(posedge clk_i);
    intg_req_i <= 1'b1;
    for (n = 0; n < 1000 && !integrating_o; n++)
    begin
      @(negedge clk_i);
      if (light_driver_enable_o && !integrating_o)
        c++;
    end
    check("intg started", 32'(integrating_o), 32'h1);
    check("lead cycles", 32'(c), 32'(lead));
    repeat (4) @(negedge clk_i);
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk_i);
      if (hold)
      begin
        check("pos held", 32'(illum_mod_pos_o), 32'(lvl));
        check("neg held", 32'(illum_mod_neg_o), 32'(!lvl));
        check("demod held", 32'(pixel_demod_o), 32'(!lvl));
      end
    end
    @(posedge clk_i);
    intg_req_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    check("enable off", 32'(light_driver_enable_o), 32'h0);
  endtask : run_intg

  // ------
  // Read monitor
  // ------
  always @(negedge clk_i)
    if (ack_o && !we_i)
    begin
      if (exp_q.size() == 0)
        check("read queue", 32'h1, 32'h0);
      else
        check("read data", dat_o, exp_q.pop_front());
    end

  initial
  begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end

  // ------
  // Main sequence
  // ------
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, tmic_pkg::ADDR_CTRL, 32'(tmic_pkg::CTRL_RST));
    wb(1'b0, tmic_pkg::ADDR_PLL_INT, {17'h0, tmic_pkg::PLL_PS_RST, tmic_pkg::PLL_N_RST,
      tmic_pkg::PLL_M_RST});
    wb(1'b0, tmic_pkg::ADDR_PLL_FRA, 32'(tmic_pkg::PLL_FRAC_RST));
    wb(1'b0, tmic_pkg::ADDR_TRIM, 32'h0);
    wb(1'b0, tmic_pkg::ADDR_QUAD, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    check("shutter idle", 32'(shutter_switch_on_o), 32'h0);
    check("pos idle", 32'(illum_mod_pos_o), 32'h0);
    check("neg idle", 32'(illum_mod_neg_o), 32'h1);
    wb(1'b1, tmic_pkg::ADDR_TRIM, 32'h1f);
    wb(1'b0, tmic_pkg::ADDR_TRIM, {27'h0, 1'b1, tmic_pkg::TRIM_MAX});
    wb(1'b1, tmic_pkg::ADDR_TRIM, 32'h3);
    run_intg(tmic_pkg::GUARD_CYC, 1'b0, 1'b0);
    check("light pulses", 32'(pulses > 0), 32'h1);
    wb(1'b1, tmic_pkg::ADDR_CTRL, 32'h18);
    run_intg(tmic_pkg::ADVANCE_CYC, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      wb(1'b1, tmic_pkg::ADDR_CTRL, 32'h11 | 32'(k << 2) | 32'((1 - k) << 1));
      run_intg(tmic_pkg::GUARD_CYC, 1'b1, 1'(k));
    end
    wb(1'b1, tmic_pkg::ADDR_CTRL, 32'h0);
    check("shutter off", 32'(shutter_switch_on_o), 32'h1);
    off = 2'($random(seed)) | 2'h1;
    wb(1'b1, tmic_pkg::ADDR_QUAD, 32'(off));
    wb(1'b1, tmic_pkg::ADDR_CTRL, 32'h30);
    pulse(1'b1);
    check("odd quad", 32'(quad_index_o), 32'(off));
    for (int k = 1; k < 5; k++)
    begin
      pulse(1'b0);
      check("odd step", 32'(quad_index_o), 32'(2'(off + 2'(k))));
    end
    pulse(1'b1);
    check("even quad", 32'(quad_index_o), 32'h0);
    pulse(1'b0);
    check("even step", 32'(quad_index_o), 32'h1);
    // Step is the modulation frequency over the 20 MHz clock, whole cycles dropped
    // 48 MHz gives 0.4 of a turn, 17.5 x 24 MHz / 8 = 52.5 MHz gives 0.625
    wb(1'b1, tmic_pkg::ADDR_PLL_INT, 32'h0911);
    wb(1'b0, tmic_pkg::ADDR_PLL_INT, 32'h0911);
    wb(1'b1, tmic_pkg::ADDR_PLL_FRA, 32'h8000);
    wb(1'b0, tmic_pkg::ADDR_FREQ, 32'h66666666);
    wb(1'b1, tmic_pkg::ADDR_PLL_UPD, 32'h1);
    wb(1'b0, tmic_pkg::ADDR_FREQ, 32'h66666666);
    wb(1'b1, tmic_pkg::ADDR_PLL_UPD, 32'h0);
    wb(1'b0, tmic_pkg::ADDR_PLL_UPD, 32'h0);
    wb(1'b0, tmic_pkg::ADDR_FREQ, 32'ha0000000);
    check("standby emission", 32'(fault), 32'h0);
    stop_test();
  end
endmodule : tof_modulation_illum_control_bench

// >>> logic/tmic_ctrl.sv
// Purpose: Modulation and illumination control with Wishbone registers
// Assumes: Integration window and quad/sub-frame strobes from timing generator
// Notes:   Single-cycle-late ack; unmapped reads return zero
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
module tmic_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        intg_req_i,
  input  wire logic        quad_start_i,
  input  wire logic        subframe_start_i,
  output logic             illum_mod_pos_o,
  output logic             illum_mod_neg_o,
  output logic             pixel_demod_o,
  output logic             light_driver_enable_o,
  output logic             shutter_switch_on_o,
  output logic             integrating_o,
  output logic [1:0]       quad_index_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    tmic_pkg::tmic_state_t st;
    logic [8:0]  cnt;
    logic        ack;
    logic [31:0] rdat;
    logic [5:0]  ctrl;
    logic        trim_dir;
    logic [3:0]  trim;
    logic [1:0]  hop_off;
    // Shadow PLL settings, written by software
    logic [7:0]  m_sh;
    logic [2:0]  n_sh;
    logic [3:0]  ps_sh;
    logic [15:0] frac_sh;
    // Live PLL settings, loaded on the apply strobe
    logic [7:0]  m;
    logic [2:0]  n;
    logic [3:0]  ps;
    logic [15:0] frac;
    logic        upd;
    logic [1:0]  quad;
    logic        odd_sf;
    logic [31:0] step;
  } tmic_ctrl_t;

  tmic_ctrl_t s_r;
  tmic_ctrl_t s_nxt;
  logic       wr;
  logic       rd;
  logic       active;
  logic [1:0] eff_quad;
  logic       in_intg;
  logic       lead_cond;
  logic [8:0] lead_load;
  logic [6:0] status;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Byte-lane merge of a register
  function automatic logic [31:0] tmic_merge(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction : tmic_merge

  // Accumulator step per 20 MHz clock for the programmed frequency
  function automatic logic [31:0] tmic_step(input logic [7:0]  m,
                                            input logic [15:0] frac,
                                            input logic [2:0]  n,
                                            input logic [3:0]  ps);
    logic [63:0] num;
    logic [63:0] den;
    logic [4:0]  div;
    // Five bits so that a prescaler of 15 cannot wrap to a zero divisor
    div = 5'({1'b0, ps} + 5'h1);
    num = ({40'h0, m, 16'h0} + {48'h0, frac})
          * 64'(tmic_pkg::REF_MHZ);
    den = 64'(tmic_pkg::CLK_MHZ) * {61'h0, tmic_pkg::QUADS}
          * {59'h0, div};
    den = den << (n - 3'h1);
    return 32'((num << 16) / den);
  endfunction : tmic_step

  // ------------------------------------------------------------
  // Bus strobes, quad index and counter loads
  // ------------------------------------------------------------
  // Gating on ack keeps a held request from being taken twice
  assign wr       = cyc_i & stb_i & we_i & ~s_r.ack;
  assign rd       = cyc_i & stb_i & ~we_i & ~s_r.ack;
  // Odd sub-frames shift the sequence when hopping is on
  assign eff_quad = (s_r.ctrl[tmic_pkg::CTRL_HOPEN] && s_r.odd_sf)
                    ? 2'(s_r.quad + s_r.hop_off)
                    : s_r.quad;
  assign in_intg  = (s_r.st == tmic_pkg::TMIC_INTG);
  assign active   = in_intg;
  assign lead_cond = s_r.ctrl[tmic_pkg::CTRL_ADVANCE];
  // Lead time: one guard cycle, or the advance time ahead of integration
  assign lead_load = lead_cond ? 9'(tmic_pkg::ADVANCE_CNT - 9'h1)
                               : 9'(tmic_pkg::GUARD_CNT - 9'h1);
  assign status    = {s_r.odd_sf, eff_quad, s_r.quad, s_r.st};

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic [31:0] w;
    w     = 32'h0;
    s_nxt = s_r;
    // Ack stands one cycle and drops before the master releases
    s_nxt.ack  = cyc_i & stb_i & ~s_r.ack;
    s_nxt.rdat = 32'h0;

    // ----------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------
    if (wr)
    begin
      case (adr_i)
        tmic_pkg::ADDR_CTRL:
        begin
          w = tmic_merge({26'h0, s_r.ctrl}, dat_i, sel_i);
          s_nxt.ctrl = w[5:0];
        end
        tmic_pkg::ADDR_TRIM:
        begin
          w = tmic_merge({27'h0, s_r.trim_dir, s_r.trim}, dat_i, sel_i);
          s_nxt.trim_dir = w[tmic_pkg::TRIM_DIR];
          // Clamp guards the driver from over-trim
          s_nxt.trim = (w[3:0] > tmic_pkg::TRIM_MAX) ? tmic_pkg::TRIM_MAX : w[3:0];
        end
        tmic_pkg::ADDR_QUAD:
        begin
          w = tmic_merge({30'h0, s_r.hop_off}, dat_i, sel_i);
          s_nxt.hop_off = w[1:0];
        end
        tmic_pkg::ADDR_PLL_INT:
        begin
          w = tmic_merge({17'h0, s_r.ps_sh, s_r.n_sh, s_r.m_sh}, dat_i, sel_i);
          s_nxt.m_sh  = w[7:0];
          s_nxt.n_sh  = w[10:8];
          s_nxt.ps_sh = w[14:11];
        end
        tmic_pkg::ADDR_PLL_FRA:
        begin
          w = tmic_merge({16'h0, s_r.frac_sh}, dat_i, sel_i);
          s_nxt.frac_sh = w[15:0];
        end
        tmic_pkg::ADDR_PLL_UPD:
        begin
          if (sel_i[0])
          begin
            s_nxt.upd = dat_i[0];
            // Falling edge of the strobe commits the shadows
            // Shadows let software change every field before one switch-over
            if (s_r.upd && !dat_i[0])
            begin
              s_nxt.m    = s_r.m_sh;
              s_nxt.n    = s_r.n_sh;
              s_nxt.ps   = s_r.ps_sh;
              s_nxt.frac = s_r.frac_sh;
              s_nxt.step = tmic_step(s_r.m_sh, s_r.frac_sh, s_r.n_sh, s_r.ps_sh);
            end
          end
        end
        default:
        begin
        end
      endcase
    end

    // ----------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------
    if (rd)
    begin
      case (adr_i)
        tmic_pkg::ADDR_CTRL:    s_nxt.rdat = {26'h0, s_r.ctrl};
        tmic_pkg::ADDR_TRIM:    s_nxt.rdat = {27'h0, s_r.trim_dir, s_r.trim};
        tmic_pkg::ADDR_QUAD:    s_nxt.rdat = {30'h0, s_r.hop_off};
        tmic_pkg::ADDR_PLL_INT: s_nxt.rdat = {17'h0, s_r.ps_sh, s_r.n_sh, s_r.m_sh};
        tmic_pkg::ADDR_PLL_FRA: s_nxt.rdat = {16'h0, s_r.frac_sh};
        tmic_pkg::ADDR_PLL_UPD: s_nxt.rdat = {31'h0, s_r.upd};
        tmic_pkg::ADDR_STATUS:  s_nxt.rdat = {25'h0, status};
        tmic_pkg::ADDR_FREQ:    s_nxt.rdat = s_r.step;
        default:                s_nxt.rdat = 32'h0;
      endcase
    end

    // ----------------------------------------------------------
    // Quad stepping and sub-frame parity
    // ----------------------------------------------------------
    if (subframe_start_i)
    begin
      s_nxt.odd_sf = ~s_r.odd_sf;
      s_nxt.quad   = 2'h0;
    end
    else if (quad_start_i)
      s_nxt.quad = 2'(s_r.quad + 2'h1);

    // ----------------------------------------------------------
    // Integration window sequencing
    // ----------------------------------------------------------
    // Counter runs down to zero and holds; leaving IDLE or INTG reloads it
    s_nxt.cnt = (s_r.cnt != 9'h0) ? 9'(s_r.cnt - 9'h1) : 9'h0;
    case (s_r.st)
      tmic_pkg::TMIC_IDLE:
        if (intg_req_i)
        begin
          s_nxt.st  = tmic_pkg::TMIC_LEAD;
          s_nxt.cnt = lead_load;
        end
      tmic_pkg::TMIC_LEAD:
        if (s_r.cnt == 9'h0)
          s_nxt.st = tmic_pkg::TMIC_INTG;
      tmic_pkg::TMIC_INTG:
        if (!intg_req_i)
        begin
          s_nxt.st  = tmic_pkg::TMIC_TAIL;
          s_nxt.cnt = 9'(tmic_pkg::GUARD_CNT - 9'h1);
        end
      tmic_pkg::TMIC_TAIL:
        if (s_r.cnt == 9'h0)
          s_nxt.st = tmic_pkg::TMIC_IDLE;
      default:
        s_nxt.st = tmic_pkg::TMIC_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Start-up settings give the base modulation frequency
      s_r          <= '0;
      s_r.st       <= tmic_pkg::TMIC_IDLE;
      s_r.ctrl     <= tmic_pkg::CTRL_RST;
      s_r.m_sh     <= tmic_pkg::PLL_M_RST;
      s_r.n_sh     <= tmic_pkg::PLL_N_RST;
      s_r.ps_sh    <= tmic_pkg::PLL_PS_RST;
      s_r.frac_sh  <= tmic_pkg::PLL_FRAC_RST;
      s_r.m        <= tmic_pkg::PLL_M_RST;
      s_r.n        <= tmic_pkg::PLL_N_RST;
      s_r.ps       <= tmic_pkg::PLL_PS_RST;
      s_r.frac     <= tmic_pkg::PLL_FRAC_RST;
      s_r.step     <= tmic_step(tmic_pkg::PLL_M_RST, tmic_pkg::PLL_FRAC_RST,
                                tmic_pkg::PLL_N_RST, tmic_pkg::PLL_PS_RST);
    end
    else
      s_r <= s_nxt;
  end

  // ------------------------------------------------------------
  // Waveform generator
  // ------------------------------------------------------------
  tmic_mod_gen u_gen (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .active_i   (active),
    .hold_i     (s_r.ctrl[tmic_pkg::CTRL_HOLD]),
    .light_dc_i (s_r.ctrl[tmic_pkg::CTRL_LIGHTDC]),
    .pixel_dc_i (s_r.ctrl[tmic_pkg::CTRL_PIXDC]),
    .trim_dir_i (s_r.trim_dir),
    .trim_i     (s_r.trim),
    .phase_i    ({eff_quad, 14'h0}),
    .step_i     (s_r.step),
    .mod_pos_o  (illum_mod_pos_o),
    .mod_neg_o  (illum_mod_neg_o),
    .demod_o    (pixel_demod_o)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign dat_o                 = s_r.rdat;
  assign ack_o                 = s_r.ack;
  assign light_driver_enable_o = (s_r.st != tmic_pkg::TMIC_IDLE);
  // Switch stays on at all times when shutter operation is off
  assign shutter_switch_on_o   = ~s_r.ctrl[tmic_pkg::CTRL_SHUTEN] | in_intg;
  assign integrating_o         = in_intg;
  assign quad_index_o          = eff_quad;

endmodule : tmic_ctrl

// >>> logic/tmic_mod_gen.sv
// Purpose: Modulation waveform pair with duty trim, phase offset and hold
// Assumes: Modulation clock emulated by a phase accumulator on clk_i
// Notes:   Trim in accumulator units stands for ~450 ps steps
`timescale 1ns/1ps
module tmic_mod_gen (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        active_i,
  input  wire logic        hold_i,
  input  wire logic        light_dc_i,
  input  wire logic        pixel_dc_i,
  input  wire logic        trim_dir_i,
  input  wire logic [3:0]  trim_i,
  input  wire logic [15:0] phase_i,
  input  wire logic [31:0] step_i,
  output logic             mod_pos_o,
  output logic             mod_neg_o,
  output logic             demod_o
);

  typedef struct packed {
    logic [31:0] acc;
    logic        pos;
    logic        neg;
    logic        dem;
  } tmic_gen_t;

  tmic_gen_t s_r;
  tmic_gen_t s_nxt;
  logic [15:0] lpos;
  logic [15:0] thr;
  logic [15:0] trim_w;

  always_comb
  begin
    s_nxt  = s_r;
    trim_w = {4'h0, trim_i, 8'h00};
    lpos   = 16'(s_r.acc[31:16] + phase_i);
    // Duty threshold around half period
    if (trim_dir_i)
      thr = 16'(16'h8000 - trim_w);
    else
      thr = 16'(16'h8000 + trim_w);
    s_nxt.acc = active_i ? 32'(s_r.acc + step_i) : 32'h0;
    if (!active_i)
    begin
      s_nxt.pos = 1'b0;
      s_nxt.neg = 1'b1;
      s_nxt.dem = 1'b0;
    end
    else if (hold_i)
    begin
      s_nxt.pos = light_dc_i;
      s_nxt.neg = ~light_dc_i;
      s_nxt.dem = pixel_dc_i;
    end
    else
    begin
      s_nxt.pos = (lpos < thr);
      s_nxt.neg = ~(lpos < thr);
      s_nxt.dem = (s_r.acc[31:16] < 16'h8000);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '{acc: 32'h0, pos: 1'b0, neg: 1'b1, dem: 1'b0};
    else
      s_r <= s_nxt;
  end

  assign mod_pos_o = s_r.pos;
  assign mod_neg_o = s_r.neg;
  assign demod_o   = s_r.dem;

endmodule : tmic_mod_gen

// >>> logic/tmic_pkg.sv
// Purpose: Constants and types for the modulation and illumination control block
// Assumes: 20 MHz system clock, classic Wishbone register access
// Notes:   Overview of operation list below
//
// Overview of operation
// - Shutter inactive (switch on) from integration start, active (off) at its end
// - Positive illumination output toggles during integration, low otherwise
// - Negative illumination output toggles during integration, high otherwise
// - Light driver enable rises before integration, falls after it
// - Modulation hold set to 1 stops toggling during integration
// - Held: positive output equals light DC level, negative its complement
// - Advance set: driver enable asserted 15 us before integration
// - Trim direction 0 widens positive high time, 1 narrows it
// - Duty trim in ~450 ps steps, software keeps it at most 11
// - Quad hopping gives odd sub-frames a different phase sequence
// - Alternate sub-frames add hop offset to nominal quad index
// - Phase equals 360 times effective quad over phases per frequency
// - Frequency is M times 24 MHz over 2^(N-1), quads, (1+prescaler)
// - Effective multiplier is integer plus fraction over 2^16
// - Start-up: M 16, fraction 0, N 1, prescaler 1, 48 MHz
// - Frequency settings apply only on apply strobe write of 1 then 0
// - Phase steps automatically quad to quad, each quad adds 90 degrees
// - Shutter enable defaults 1; disabled keeps switch on always

package tmic_pkg;

  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_TRIM    = 8'h04;
  localparam logic [7:0] ADDR_QUAD    = 8'h08;
  localparam logic [7:0] ADDR_PLL_INT = 8'h0c;
  localparam logic [7:0] ADDR_PLL_FRA = 8'h10;
  localparam logic [7:0] ADDR_PLL_UPD = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_FREQ    = 8'h1c;

  // ------------------------------------------------------------
  // Control and trim register bit positions
  // ------------------------------------------------------------
  localparam int CTRL_HOLD    = 0;
  localparam int CTRL_PIXDC   = 1;
  localparam int CTRL_LIGHTDC = 2;
  localparam int CTRL_ADVANCE = 3;
  localparam int CTRL_SHUTEN  = 4;
  localparam int CTRL_HOPEN   = 5;
  localparam int TRIM_DIR     = 4;

  // ------------------------------------------------------------
  // Reset values and constants
  // ------------------------------------------------------------
  localparam logic [5:0]  CTRL_RST     = 6'h10;
  localparam logic [7:0]  PLL_M_RST    = 8'h10;
  localparam logic [15:0] PLL_FRAC_RST = 16'h0000;
  localparam logic [2:0]  PLL_N_RST    = 3'h1;
  localparam logic [3:0]  PLL_PS_RST   = 4'h1;
  localparam logic [3:0]  TRIM_MAX     = 4'hb;
  localparam logic [2:0]  QUADS        = 3'h4;
  localparam int          REF_MHZ      = 24;
  localparam int          TRIM_STEP_PS = 450;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ        = 20;
  localparam int ADVANCE_US     = 15;
  localparam int ADVANCE_CYC    = ADVANCE_US * CLK_MHZ;
  localparam int GUARD_CYC      = 1;
  localparam logic [8:0] ADVANCE_CNT = 9'(ADVANCE_CYC);
  localparam logic [8:0] GUARD_CNT   = 9'(GUARD_CYC);

  typedef enum logic [1:0] {TMIC_IDLE, TMIC_LEAD, TMIC_INTG, TMIC_TAIL} tmic_state_t;

endpackage : tmic_pkg
